/* shared/l2ba_pkg.sv */
package l2ba_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Register byte addresses on the bus.
    localparam logic [31:0] L2BA_ADR_DMA_SRC  = 32'h0182_0108;
    localparam logic [31:0] L2BA_ADR_DMA_DST  = 32'h0182_010c;
    localparam logic [31:0] L2BA_ADR_DMA_CNT  = 32'h0182_0110;
    localparam logic [31:0] L2BA_ADR_CORE_PRI = 32'h0184_1000;
    localparam logic [31:0] L2BA_ADR_CONFIG   = 32'h0184_1004;
    localparam logic [31:0] L2BA_ADR_STATUS   = 32'h0184_1008;
    localparam logic [31:0] L2BA_ADR_MST_PRI1 = 32'h01c1_4114;
    localparam logic [31:0] L2BA_ADR_MST_PRI2 = 32'h01c1_4118;

    ////////////////////////////////////////////////////////////////////////////
    // Field layout.
    localparam int PRI_W          = 3;
    localparam int CORE_PRI_LSB   = 0;
    localparam int DMA_PRI_LSB    = 28;
    localparam int MST_FIELD_W    = 4;
    localparam int MST_PER_REG    = 8;
    localparam int CFG_LIMIT_LSB  = 0;
    localparam int CFG_ERRATA_BIT = 8;
    localparam int STAT_LOCAL_DMA_ENGINE_LSB  = 0;
    localparam int STAT_SLAVE_DMA_PORT_LSB  = 8;
    localparam int STAT_CORE_LSB  = 16;
    localparam int STAT_GNT_LSB   = 24;

    ////////////////////////////////////////////////////////////////////////////
    // Reset values and fixed levels.
    localparam logic [31:0]      CORE_PRI_RST  = 32'h0000_0001;
    localparam logic [31:0]      CONFIG_RST    = 32'h0000_0010;
    localparam logic [31:0]      MST_PRI_RST   = 32'h0000_0000;
    localparam logic [31:0]      DMA_REG_RST   = 32'h0000_0000;
    localparam logic [PRI_W-1:0] CMD_PRI_LEVEL = 3'h7;

    // Current owner of the RAM slice, Gray coded along none, core, local, port.
    typedef enum logic [1:0] {
        OWN_NONE = 2'b00,
        OWN_CORE = 2'b01,
        OWN_LOCAL_DMA_ENGINE = 2'b11,
        OWN_SLAVE_DMA_PORT = 2'b10
    } l2ba_owner_t;

endpackage

/* design/l2ba_wait_counter.sv */
module l2ba_wait_counter #(
    parameter int CNT_W = 6
) (
    input  wire logic             mclk,
    input  wire logic             rst,
    input  wire logic             waiting,
    input  wire logic             blocked,
    input  wire logic             served,
    input  wire logic [CNT_W-1:0] limit,
    output logic      [CNT_W-1:0] count,
    output logic                  starving
);
    import l2ba_pkg::*;

    logic [CNT_W-1:0] count_q;
    logic [CNT_W-1:0] count_d;

    ////////////////////////////////////////////////////////////////////////////
    // Counting stops at the limit so the value never wraps back to a low count.
    always_comb begin
        count_d = count_q;
        if (served || !waiting) begin
            count_d = '0;
        end else if (blocked && (count_q < limit)) begin
            count_d = count_q + 1'b1;
        end
    end

    // One process holds the wait count.
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            count_q <= '0;
        end else begin
            count_q <= count_d;
        end
    end

    // A limit of zero turns the boost off for this requester.
    assign count    = count_q;
    assign starving = waiting && (limit != '0) && (count_q >= limit);

endmodule

/* design/l2ba_arbiter.sv */
// Functional notes
// RULE1: Core and DMA requests to the RAM compete, each with a priority and a wait counter.
// RULE2: Every non-core request, local engine or slave port master, is treated as DMA.
// RULE3: A wait counter climbs each cycle its request is held off by higher priority.
// RULE4: A counter at its wait limit lifts its request above all others for one slice.
// RULE5: Equal-priority core and DMA requests alternate so they share bandwidth evenly.
// RULE6: In affected-silicon mode the core always wins equal-priority ties.
// RULE7: In affected-silicon mode slave port requests stall while the core is at level 7.
// RULE8: Software should keep DMA and core priorities apart to avoid the tie behaviour.
// RULE9: Local engine and slave port at equal priority simply alternate, no penalty.
// RULE10: The core priority lives in a writable register at 0x01841000.
// RULE11: The local DMA priority is a shifted field of the count register at 0x01820110.
// RULE12: Slave port priority comes from the master's field at 0x01c14114 or 0x01c14118.
// RULE13: Priorities are three bits, and a lower value is the higher priority.
module l2ba_arbiter #(
    parameter int CNT_W     = 6,
    parameter int N_MASTERS = 16
) (
    input  wire logic        mclk,
    input  wire logic        rst,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [31:0] wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    input  wire logic        coreReq,
    input  wire logic        idmaReq,
    input  wire logic        sdmaReq,
    input  wire logic [3:0]  sdmaMasterId,
    output logic             coreGnt,
    output logic             idmaGnt,
    output logic             sdmaGnt
);
    import l2ba_pkg::*;

    // The master table holds two registers of eight four-bit fields.
    if (N_MASTERS < 1 || N_MASTERS > 2 * MST_PER_REG || CNT_W < 1 || CNT_W > 8) begin : g_chk
        $error("l2ba_arbiter: unsupported N_MASTERS or CNT_W");
    end

    logic [31:0]      dmaSrc_q;
    logic [31:0]      dmaDst_q;
    logic [31:0]      dmaCnt_q;
    logic [31:0]      corePriReg_q;
    logic [31:0]      config_q;
    logic [31:0]      bus_master_priority_1_q;
    logic [31:0]      bus_master_priority_2_q;
    logic [31:0]      rdData;
    logic             wbAck_q;
    logic [31:0]      wbDat_q;
    logic             wbReq;
    logic             wbWrite;
    logic [PRI_W-1:0] corePri;
    logic [PRI_W-1:0] idmaPri;
    logic [PRI_W-1:0] sdmaPri;
    logic [PRI_W-1:0] masterPri [N_MASTERS];
    logic [CNT_W-1:0] waitLimit;
    logic             errataMode;
    logic             sdmaStalled;
    logic             sdmaValid;
    logic [CNT_W-1:0] coreCount;
    logic [CNT_W-1:0] idmaCount;
    logic [CNT_W-1:0] sdmaCount;
    logic             coreStarve;
    logic             idmaStarve;
    logic             sdmaStarve;
    logic [PRI_W:0]   coreKey;
    logic [PRI_W:0]   idmaKey;
    logic [PRI_W:0]   sdmaKey;
    logic [PRI_W:0]   dmaKey;
    logic             dmaValid;
    logic             dmaPickSdma;
    logic             dmaTie;
    logic             coreDmaTie;
    l2ba_owner_t      owner;
    logic [PRI_W-1:0] winPri;
    logic             dmaTurn_q;
    logic             coreTurn_q;
    logic             coreGnt_q;
    logic             idmaGnt_q;
    logic             sdmaGnt_q;

    ////////////////////////////////////////////////////////////////////////////
    // Byte-lane merge for register writes.
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] sel);
        logic [31:0] res;
        res = old;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                res[b*8 +: 8] = nw[b*8 +: 8];
            end
        end
        return res;
    endfunction

    // A request is served once; ack drops in the cycle after it was given.
    assign wbReq   = wb_cyc_i && wb_stb_i && !wbAck_q;
    assign wbWrite = wbReq && wb_we_i;

    ////////////////////////////////////////////////////////////////////////////
    // Bus answer: one wait state, read data registered with the ack.
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            wbAck_q <= 1'b0;
            wbDat_q <= '0;
        end else begin
            wbAck_q <= wbReq;
            wbDat_q <= wbReq && !wb_we_i ? rdData : '0;
        end
    end

    // Write effects on the local DMA channel registers.
    // RULE11: priority written with the byte count
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            dmaSrc_q <= DMA_REG_RST;
            dmaDst_q <= DMA_REG_RST;
            dmaCnt_q <= DMA_REG_RST;
        end else if (wbWrite) begin
            if (wb_adr_i == L2BA_ADR_DMA_SRC) begin
                dmaSrc_q <= merge(dmaSrc_q, wb_dat_i, wb_sel_i);
            end
            if (wb_adr_i == L2BA_ADR_DMA_DST) begin
                dmaDst_q <= merge(dmaDst_q, wb_dat_i, wb_sel_i);
            end
            if (wb_adr_i == L2BA_ADR_DMA_CNT) begin
                dmaCnt_q <= merge(dmaCnt_q, wb_dat_i, wb_sel_i);
            end
        end
    end

    // Core priority and arbiter configuration.
    // RULE10: core priority register write
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            corePriReg_q <= CORE_PRI_RST;
            config_q     <= CONFIG_RST;
        end else if (wbWrite) begin
            if (wb_adr_i == L2BA_ADR_CORE_PRI) begin
                corePriReg_q <= merge(corePriReg_q, wb_dat_i, wb_sel_i);
            end
            if (wb_adr_i == L2BA_ADR_CONFIG) begin
                config_q <= merge(config_q, wb_dat_i, wb_sel_i);
            end
        end
    end

    // System master priority table.
    // RULE12: master priority registers
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            bus_master_priority_1_q <= MST_PRI_RST;
            bus_master_priority_2_q <= MST_PRI_RST;
        end else if (wbWrite) begin
            if (wb_adr_i == L2BA_ADR_MST_PRI1) begin
                bus_master_priority_1_q <= merge(bus_master_priority_1_q, wb_dat_i, wb_sel_i);
            end
            if (wb_adr_i == L2BA_ADR_MST_PRI2) begin
                bus_master_priority_2_q <= merge(bus_master_priority_2_q, wb_dat_i, wb_sel_i);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read mux; unmapped addresses answer with zero so the bus never hangs.
    always_comb begin
        rdData = '0;
        case (wb_adr_i)
            L2BA_ADR_DMA_SRC:  rdData = dmaSrc_q;
            L2BA_ADR_DMA_DST:  rdData = dmaDst_q;
            L2BA_ADR_DMA_CNT:  rdData = dmaCnt_q;
            L2BA_ADR_CORE_PRI: rdData = corePriReg_q;
            L2BA_ADR_CONFIG:   rdData = config_q;
            L2BA_ADR_MST_PRI1: rdData = bus_master_priority_1_q;
            L2BA_ADR_MST_PRI2: rdData = bus_master_priority_2_q;
            L2BA_ADR_STATUS: begin
                rdData[STAT_LOCAL_DMA_ENGINE_LSB +: CNT_W] = idmaCount;
                rdData[STAT_SLAVE_DMA_PORT_LSB +: CNT_W] = sdmaCount;
                rdData[STAT_CORE_LSB +: CNT_W] = coreCount;
                rdData[STAT_GNT_LSB +: 3]      = {sdmaGnt_q, idmaGnt_q, coreGnt_q};
            end
            default: rdData = '0;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // Priority fields; the master table is one field per master.
    // RULE13: three-bit levels
    for (genvar m = 0; m < N_MASTERS; m++) begin : g_mst
        if (m < MST_PER_REG) begin : g_lo
            assign masterPri[m] = bus_master_priority_1_q[m*MST_FIELD_W +: PRI_W];
        end else begin : g_hi
            assign masterPri[m] = bus_master_priority_2_q[(m-MST_PER_REG)*MST_FIELD_W +: PRI_W];
        end
    end

    assign corePri    = corePriReg_q[CORE_PRI_LSB +: PRI_W];
    assign idmaPri    = dmaCnt_q[DMA_PRI_LSB +: PRI_W];
    // An out-of-range master id falls back to the lowest priority.
    assign sdmaPri    = (int'(sdmaMasterId) < N_MASTERS) ? masterPri[sdmaMasterId] : 3'h7;
    assign waitLimit  = config_q[CFG_LIMIT_LSB +: CNT_W];
    assign errataMode = config_q[CFG_ERRATA_BIT];

    // RULE7: level-7 command logic starves the port
    assign sdmaStalled = errataMode && (corePri == CMD_PRI_LEVEL);
    assign sdmaValid   = sdmaReq && !sdmaStalled;

    ////////////////////////////////////////////////////////////////////////////
    // Sort keys: a starving request drops its top bit and outranks every request that is not starving.
    // RULE4: boost a starved request
    assign coreKey = {!coreStarve, corePri};
    assign idmaKey = {!idmaStarve, idmaPri};
    assign sdmaKey = {!sdmaStarve, sdmaPri};

    // Pick between the two DMA sources first; both count as one class.
    // RULE2: local and port requests are DMA
    // RULE9: equal local and port take turns
    always_comb begin
        dmaTie      = idmaReq && sdmaValid && (idmaKey == sdmaKey);
        dmaPickSdma = 1'b0;
        if (idmaReq && sdmaValid) begin
            dmaPickSdma = dmaTie ? dmaTurn_q : (sdmaKey < idmaKey);
        end else begin
            dmaPickSdma = sdmaValid;
        end
        dmaValid = idmaReq || sdmaValid;
        dmaKey   = dmaPickSdma ? sdmaKey : idmaKey;
    end

    // Core against the DMA class.
    // RULE1: core against DMA
    // RULE5: ties alternate in intended mode
    // RULE6: ties favour the core in affected mode
    always_comb begin
        coreDmaTie = coreReq && dmaValid && (coreKey == dmaKey);
        owner      = OWN_NONE;
        if (coreReq && (!dmaValid || (coreKey < dmaKey) ||
                        (coreDmaTie && (errataMode || !coreTurn_q)))) begin
            owner = OWN_CORE;
        end else if (dmaValid) begin
            owner = dmaPickSdma ? OWN_SLAVE_DMA_PORT : OWN_LOCAL_DMA_ENGINE;
        end
    end

    // Raw priority of the winner, used to decide who was held off.
    always_comb begin
        case (owner)
            OWN_CORE: winPri = corePri;
            OWN_LOCAL_DMA_ENGINE: winPri = idmaPri;
            OWN_SLAVE_DMA_PORT: winPri = sdmaPri;
            default:  winPri = 3'h7;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // One wait counter per requester: core, local engine, port. Equal-priority losses do not count,
    // which is what lets the core lock out DMA in affected mode.
    // RULE3: count cycles held off by higher priority
    l2ba_wait_counter #(.CNT_W(CNT_W)) u_core_wait (
        .mclk     (mclk),
        .rst      (rst),
        .waiting  (coreReq),
        .blocked  (owner != OWN_CORE && owner != OWN_NONE && winPri < corePri),
        .served   (owner == OWN_CORE),
        .limit    (waitLimit),
        .count    (coreCount),
        .starving (coreStarve)
    );

    l2ba_wait_counter #(.CNT_W(CNT_W)) u_local_dma_engine_wait (
        .mclk     (mclk),
        .rst      (rst),
        .waiting  (idmaReq),
        .blocked  (owner != OWN_LOCAL_DMA_ENGINE && owner != OWN_NONE && winPri < idmaPri),
        .served   (owner == OWN_LOCAL_DMA_ENGINE),
        .limit    (waitLimit),
        .count    (idmaCount),
        .starving (idmaStarve)
    );

    // A stalled port request waits but is never counted as held off.
    l2ba_wait_counter #(.CNT_W(CNT_W)) u_slave_dma_port_wait (
        .mclk     (mclk),
        .rst      (rst),
        .waiting  (sdmaReq),
        .blocked  (sdmaValid && owner != OWN_SLAVE_DMA_PORT && owner != OWN_NONE && winPri < sdmaPri),
        .served   (owner == OWN_SLAVE_DMA_PORT),
        .limit    (waitLimit),
        .count    (sdmaCount),
        .starving (sdmaStarve)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Turn flags point at the side that lost the last tie.
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            dmaTurn_q  <= 1'b0;
            coreTurn_q <= 1'b0;
        end else begin
            if (dmaTie && (owner == OWN_LOCAL_DMA_ENGINE || owner == OWN_SLAVE_DMA_PORT)) begin
                dmaTurn_q <= (owner == OWN_LOCAL_DMA_ENGINE);
            end
            if (coreDmaTie && !errataMode) begin
                coreTurn_q <= (owner == OWN_CORE);
            end
        end
    end

    // Grants are registered: one slice per cycle, one owner at a time.
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            coreGnt_q <= 1'b0;
            idmaGnt_q <= 1'b0;
            sdmaGnt_q <= 1'b0;
        end else begin
            coreGnt_q <= (owner == OWN_CORE);
            idmaGnt_q <= (owner == OWN_LOCAL_DMA_ENGINE);
            sdmaGnt_q <= (owner == OWN_SLAVE_DMA_PORT);
        end
    end

    assign coreGnt  = coreGnt_q;
    assign idmaGnt  = idmaGnt_q;
    assign sdmaGnt  = sdmaGnt_q;
    assign wb_ack_o = wbAck_q;
    assign wb_dat_o = wbDat_q;
    ////////////////////////////////////////////////////////////////////////////
    // Checks on the arbiter's own behaviour.
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    sequence s_tieOnce;
        coreDmaTie && !errataMode;
    endsequence
    sequence s_tieTwice;
        s_tieOnce ##1 s_tieOnce;
    endsequence
    a_single_owner: assert property ($onehot0({coreGnt_q, idmaGnt_q, sdmaGnt_q})) // RULE1
        else $error("more than one grant at once");
    a_dma_grant_cause: assert property (idmaGnt_q || sdmaGnt_q |-> $past(idmaReq || sdmaReq)) // RULE2
        else $error("DMA grant without a DMA request");
    a_count_climbs: assert property (idmaReq && owner != OWN_LOCAL_DMA_ENGINE && owner != OWN_NONE // RULE3
        && winPri < idmaPri && idmaCount < waitLimit |=> idmaCount == $past(idmaCount) + 1'b1)
        else $error("wait counter did not climb while held off");
    a_starve_served: assert property (idmaStarve && !coreStarve && !sdmaStarve // RULE4
        && !(sdmaValid && sdmaPri < idmaPri) |=> idmaGnt_q || sdmaGnt_q)
        else $error("starved request not granted");
    a_tie_alternates: assert property (s_tieTwice |=> coreGnt_q != $past(coreGnt_q)) // RULE5
        else $error("equal priority core and DMA did not alternate");
    a_errata_core_wins: assert property (errataMode && coreDmaTie |=> coreGnt_q) // RULE6
        else $error("affected mode tie not given to the core");
    a_level7_stall: assert property (sdmaStalled |=> !sdmaGnt_q) // RULE7
        else $error("port granted while core sits at level 7");
    a_dma_tie_turns: assert property (dmaTie && !coreReq ##1 dmaTie && !coreReq // RULE9
        |=> idmaGnt_q != $past(idmaGnt_q))
        else $error("equal local and port requests did not alternate");
    a_core_pri_write: assert property (wbWrite && wb_adr_i == L2BA_ADR_CORE_PRI // RULE10
        && wb_sel_i[0] |=> corePri == $past(wb_dat_i[PRI_W-1:0]))
        else $error("core priority write lost");
    a_ack_pulse: assert property (wbReq |=> wbAck_q ##1 !wbAck_q)
        else $error("bus ack not a single cycle");

endmodule

/* tb/l2ba_req_model.sv */
module l2ba_req_model (
    input  wire logic       mclk,
    input  wire logic       rst,
    input  wire logic       wantCore,
    input  wire logic       wantIdma,
    input  wire logic       wantSdma,
    input  wire logic [3:0] wantId,
    input  wire logic       coreGnt,
    input  wire logic       idmaGnt,
    input  wire logic       sdmaGnt,
    output logic            coreReq,
    output logic            idmaReq,
    output logic            sdmaReq,
    output logic      [3:0] sdmaMasterId,
    output int              coreCnt,
    output int              idmaCnt,
    output int              sdmaCnt
);
    timeunit 1ns;
    timeprecision 1ps;

    ////////////////////////////////////////////////////////////////////////
    // Requests are levels; an idle port shows a flipped id so no stale id is trusted.
    // all masters: local engine and port masters both ask as DMA.
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            coreReq      <= 1'b0;
            idmaReq      <= 1'b0;
            sdmaReq      <= 1'b0;
            sdmaMasterId <= 4'h0;
        end else begin
            coreReq      <= wantCore;
            idmaReq      <= wantIdma;
            sdmaReq      <= wantSdma;
            sdmaMasterId <= wantSdma ? wantId : ~sdmaMasterId;
        end
    end

    // Grants are tallied per requester so the bench can judge the share.
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            coreCnt <= 0;
            idmaCnt <= 0;
            sdmaCnt <= 0;
        end else begin
            coreCnt <= coreCnt + int'(coreGnt === 1'b1);
            idmaCnt <= idmaCnt + int'(idmaGnt === 1'b1);
            sdmaCnt <= sdmaCnt + int'(sdmaGnt === 1'b1);
        end
    end
endmodule

/* tb/l2_bandwidth_arbiter_tb.sv */
module l2_bandwidth_arbiter_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import l2ba_pkg::*;

    logic        mclk = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic [31:0] adr = 32'h0, wdat = 32'h0, rdat, rd;
    logic [3:0]  sel = 4'h0, wantId = 4'h0, mid;
    logic        ack, cReq, iReq, sReq, cGnt, iGnt, sGnt;
    logic        wC = 1'b0, wI = 1'b0, wS = 1'b0;
    int          cCnt, iCnt, sCnt, dc, di, ds;
    int          miscompares = 0, nCompared = 0;

    ////////////////////////////////////////////////////////////////////////
    // Clock at 200 MHz.
    always #2.5 mclk = ~mclk;

    l2ba_arbiter i_dut (.mclk(mclk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
        .wb_dat_o(rdat), .wb_ack_o(ack), .coreReq(cReq), .idmaReq(iReq),
        .sdmaReq(sReq), .sdmaMasterId(mid), .coreGnt(cGnt), .idmaGnt(iGnt),
        .sdmaGnt(sGnt));

    l2ba_req_model i_req (.mclk(mclk), .rst(rst), .wantCore(wC), .wantIdma(wI),
        .wantSdma(wS), .wantId(wantId), .coreGnt(cGnt), .idmaGnt(iGnt),
        .sdmaGnt(sGnt), .coreReq(cReq), .idmaReq(iReq), .sdmaReq(sReq),
        .sdmaMasterId(mid), .coreCnt(cCnt), .idmaCnt(iCnt), .sdmaCnt(sCnt));

    ////////////////////////////////////////////////////////////////////////
    // Verdict and end of run, reached from the main flow, a lost answer or the hang guard.
    task automatic testDone();
        $display("Compared %0d, mismatches %0d", nCompared, miscompares);
        if (miscompares == 0 && nCompared > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        nCompared++;
        if (seen !== exp) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // One classic cycle; the answer is awaited, never assumed.
    task automatic wbCycle(input logic w, input logic [31:0] a, input logic [31:0] d);
        int n;
        @(posedge mclk);
        cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d; sel <= 4'hf;
        for (n = 0; n < 20; n++) begin
            @(posedge mclk);
            if (ack === 1'b1) break;
        end
        if (n == 20) begin
            miscompares++;
            testDone();
        end
        rd = rdat;
        cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
    endtask

    task automatic wbRead(input string name, input logic [31:0] a, input logic [31:0] mask,
                          input logic [31:0] exp);
        wbCycle(1'b0, a, 32'h0);
        check(name, rd & mask, exp);
    endtask

    // Holds the chosen requests for n cycles and returns the grants won.
    task automatic run(input logic c, input logic i, input logic s, input logic [3:0] id,
                       input int n);
        int c0, i0, s0;
        @(posedge mclk);
        c0 = cCnt; i0 = iCnt; s0 = sCnt;
        wC <= c; wI <= i; wS <= s; wantId <= id;
        repeat (n) @(posedge mclk);
        wC <= 1'b0; wI <= 1'b0; wS <= 1'b0;
        repeat (4) @(posedge mclk);
        dc = cCnt - c0; di = iCnt - i0; ds = sCnt - s0;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Main sequence.
    initial begin
        repeat (4) @(posedge mclk);
        rst <= 1'b0;
        wbRead("core_pri_rst", L2BA_ADR_CORE_PRI, 32'h7, 32'h1);
        wbRead("config_rst", L2BA_ADR_CONFIG, 32'h13f, CONFIG_RST);
        wbRead("mst1_rst", L2BA_ADR_MST_PRI1, 32'hffff_ffff, MST_PRI_RST);
        wbRead("unmapped", 32'h0184_2000, 32'hffff_ffff, 32'h0);
        wbCycle(1'b1, L2BA_ADR_CORE_PRI, 32'h5);
        wbRead("core_pri_wr", L2BA_ADR_CORE_PRI, 32'h7, 32'h5);
        wbCycle(1'b1, L2BA_ADR_DMA_CNT, 32'h3000_0040);
        wbRead("dma_cnt_wr", L2BA_ADR_DMA_CNT, 32'h7000_0000, 32'h3000_0000);
        $display("registers done");
        // Strict order: local at 0 beats core at 1 with no boost.
        // apart: software keeps core and DMA levels different here.
        wbCycle(1'b1, L2BA_ADR_CONFIG, 32'h0);
        wbCycle(1'b1, L2BA_ADR_CORE_PRI, 32'h1);
        wbCycle(1'b1, L2BA_ADR_DMA_CNT, 32'h0000_0010);
        run(1'b1, 1'b1, 1'b0, 4'h0, 30);
        check("strict_core", dc, 0);
        check("strict_local_dma_engine", 32'(di >= 29), 1);
        // Wait limit 4 lets the blocked core in about one slice in five.
        wbCycle(1'b1, L2BA_ADR_CONFIG, 32'h4);
        wbCycle(1'b1, L2BA_ADR_CORE_PRI, 32'h5);
        run(1'b1, 1'b1, 1'b0, 4'h0, 50);
        check("boost_core", 32'(dc >= 8 && dc <= 13), 1);
        // The same limit rescues the local engine when the core sits above it.
        wbCycle(1'b1, L2BA_ADR_CORE_PRI, 32'h0);
        wbCycle(1'b1, L2BA_ADR_DMA_CNT, 32'h5000_0010);
        run(1'b1, 1'b1, 1'b0, 4'h0, 50);
        check("boost_local_dma_engine", 32'(di >= 8 && di <= 13), 1);
        $display("priority done");
        // Equal levels share evenly, unless affected mode favours the core.
        wbCycle(1'b1, L2BA_ADR_CONFIG, 32'h0);
        wbCycle(1'b1, L2BA_ADR_CORE_PRI, 32'h2);
        wbCycle(1'b1, L2BA_ADR_DMA_CNT, 32'h2000_0010);
        run(1'b1, 1'b1, 1'b0, 4'h0, 40);
        check("share", 32'(dc - di <= 2 && di - dc <= 2 && dc > 15), 1);
        wbCycle(1'b1, L2BA_ADR_CONFIG, 32'h100);
        run(1'b1, 1'b1, 1'b0, 4'h0, 40);
        check("tie_core", 32'(di == 0 && dc >= 39), 1);
        // Core at level 7 stalls the port in affected mode only.
        wbCycle(1'b1, L2BA_ADR_CORE_PRI, 32'h7);
        run(1'b0, 1'b0, 1'b1, 4'h0, 20);
        check("stall_slave_dma_port", ds, 0);
        wbCycle(1'b1, L2BA_ADR_CORE_PRI, 32'h6);
        run(1'b0, 1'b0, 1'b1, 4'h0, 20);
        check("free_slave_dma_port", 32'(ds >= 19), 1);
        $display("ties done");
        // Master 9 takes its level from the second master register.
        wbCycle(1'b1, L2BA_ADR_CONFIG, 32'h0);
        wbCycle(1'b1, L2BA_ADR_CORE_PRI, 32'h3);
        wbCycle(1'b1, L2BA_ADR_MST_PRI2, 32'h7777_7707);
        run(1'b1, 1'b0, 1'b1, 4'h9, 30);
        check("mst9_wins", 32'(dc == 0 && ds >= 29), 1);
        run(1'b1, 1'b0, 1'b1, 4'h8, 30);
        check("mst8_loses", 32'(ds == 0 && dc >= 29), 1);
        // Local engine and port at equal level alternate with no loss.
        wbCycle(1'b1, L2BA_ADR_MST_PRI2, 32'h7777_7727);
        run(1'b0, 1'b1, 1'b1, 4'h9, 40);
        check("dma_pair", 32'(di - ds <= 2 && ds - di <= 2 && di + ds >= 38), 1);
        $display("masters done");
        testDone();
    end

    // Cuts a hang short.
    initial begin
        repeat (20000) @(posedge mclk);
        miscompares++;
        testDone();
    end
endmodule
